// ### logic/icg_level_pick.sv
// Highest-numbered pending group at one priority level
`timescale 1ns/1ps
`default_nettype none
module icg_level_pick #(
    parameter logic [1:0] LEVEL = 2'h0
) (
    // Per-group pending flags and levels
    input  wire logic [icg_pkg::NUM_GROUPS-1:0]                 i_valid,
    input  wire logic [icg_pkg::NUM_GROUPS*icg_pkg::LEVEL_W-1:0] i_level,
    // Result
    output logic                                                o_any,
    output logic [icg_pkg::GROUP_W-1:0]                         o_group
);
    import icg_pkg::*;

    always_comb begin
        o_any   = 1'b0;
        o_group = '0;
        // Ascending scan so the last hit, the highest number, wins
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (i_valid[g] && i_level[g*LEVEL_W +: LEVEL_W] == LEVEL) begin
                o_any   = 1'b1;
                o_group = GROUP_W'(g);
            end
        end
    end

endmodule
`default_nettype wire

// ### logic/icg_line_map.sv
// Fixed placement of peripheral request lines into group and line slots
`timescale 1ns/1ps
`default_nettype none
module icg_line_map (
    // Peripheral side
    input  wire icg_pkg::icg_periph_req_t i_req,
    // Group request matrix, bit [g*32+l]
    output logic [icg_pkg::NUM_GROUPS*icg_pkg::GROUP_LINES-1:0] o_lines
);
    import icg_pkg::*;

    always_comb begin
        o_lines = '0;
        o_lines[0*GROUP_LINES+0] = i_req.core_system_request;
        o_lines[1*GROUP_LINES +: EXT_LINES] = i_req.ext_line;
        o_lines[1*GROUP_LINES+RTC_LINE] = i_req.rtc;
        o_lines[1*GROUP_LINES+PWR_LINE] = i_req.power;
        o_lines[2*GROUP_LINES +: PORT_LINES] = i_req.port_line;
        o_lines[3*GROUP_LINES +: PDMA_LINES] = i_req.pdma;
        o_lines[4*GROUP_LINES] = i_req.flash;
        for (int k = 0; k < 4; k++) begin
            o_lines[(5+k)*GROUP_LINES] = i_req.usart[k];
        end
        for (int k = 0; k < 2; k++) begin
            o_lines[(9+k)*GROUP_LINES]  = i_req.spi[k];
            o_lines[(11+k)*GROUP_LINES] = i_req.twi_master[k];
            o_lines[(27+k)*GROUP_LINES] = i_req.twi_slave[k];
        end
        o_lines[13*GROUP_LINES] = i_req.ssc;
        o_lines[14*GROUP_LINES +: TMR_LINES] = i_req.timer0;
        o_lines[15*GROUP_LINES] = i_req.adc;
        o_lines[16*GROUP_LINES +: TMR_LINES] = i_req.timer1;
        o_lines[17*GROUP_LINES] = i_req.usb;
        o_lines[18*GROUP_LINES] = i_req.sdram;
        o_lines[19*GROUP_LINES] = i_req.dac;
        o_lines[20*GROUP_LINES] = i_req.mci;
        o_lines[21*GROUP_LINES] = i_req.aes;
        o_lines[22*GROUP_LINES +: DMAC_LINES] = i_req.dmac;
        o_lines[26*GROUP_LINES] = i_req.msi;
        o_lines[29*GROUP_LINES] = i_req.ecc_corrector_request;
    end

endmodule
`default_nettype wire

// ### logic/icg_pkg.sv
// Package for the interrupt cause and group map block
package icg_pkg;

    localparam int unsigned NUM_GROUPS  = 64;
    localparam int unsigned GROUP_LINES = 32;
    localparam int unsigned NUM_LEVELS  = 4;
    localparam int unsigned GROUP_W     = 6;
    localparam int unsigned LEVEL_W     = 2;
    localparam int unsigned ADDR_W      = 12;

    // Register map (byte addresses)
    localparam logic [ADDR_W-1:0] PRIO_BASE_OFS  = 12'h000;
    localparam logic [ADDR_W-1:0] PRIO_LAST_OFS  = 12'h0FC;
    localparam logic [ADDR_W-1:0] REQ_BASE_OFS   = 12'h100;
    localparam logic [ADDR_W-1:0] REQ_LAST_OFS   = 12'h1FC;
    localparam logic [ADDR_W-1:0] CAUSE_LVL3_OFS = 12'h200;
    localparam logic [ADDR_W-1:0] CAUSE_LAST_OFS = 12'h20C;

    // Priority register field layout
    localparam int unsigned LEVEL_LSB  = 30;
    localparam int unsigned OFFSET_LSB = 0;
    localparam int unsigned OFFSET_W   = 14;
    localparam logic [31:0] PRIO_RESET = 32'h0000_0000;

    // Request slots of the fixed peripheral map
    localparam int unsigned EXT_LINES   = 8;
    localparam int unsigned PORT_LINES  = 14;
    localparam int unsigned PDMA_LINES  = 8;
    localparam int unsigned TMR_LINES   = 3;
    localparam int unsigned DMAC_LINES  = 5;
    localparam int unsigned RTC_LINE    = 8;
    localparam int unsigned PWR_LINE    = 9;

    typedef struct packed {
        logic [LEVEL_W-1:0]  level;
        logic [OFFSET_W-1:0] offset;
    } icg_group_cfg_t;

    typedef struct packed {
        logic              core_system_request;
        logic [EXT_LINES-1:0] ext_line;
        logic              rtc;
        logic              power;
        logic [PORT_LINES-1:0] port_line;
        logic [PDMA_LINES-1:0] pdma;
        logic              flash;
        logic [3:0]        usart;
        logic [1:0]        spi;
        logic [1:0]        twi_master;
        logic              ssc;
        logic [TMR_LINES-1:0] timer0;
        logic              adc;
        logic [TMR_LINES-1:0] timer1;
        logic              usb;
        logic              sdram;
        logic              dac;
        logic              mci;
        logic              aes;
        logic [DMAC_LINES-1:0] dmac;
        logic              msi;
        logic [1:0]        twi_slave;
        logic              ecc_corrector_request;
    } icg_periph_req_t;

    typedef struct packed {
        logic                valid;
        logic [LEVEL_W-1:0]  level;
        logic [OFFSET_W-1:0] offset;
    } icg_cpu_req_t;

endpackage

// ### logic/icg_top.sv
// Interrupt cause reporting, group priorities and fixed request map
`timescale 1ns/1ps
`default_nettype none
module icg_top (
    // Clock and reset
    input  wire logic                          i_clock,
    input  wire logic                          i_rst,
    // Peripheral requests
    input  wire icg_pkg::icg_periph_req_t      i_req,
    // Register port
    input  wire logic [icg_pkg::ADDR_W-1:0]    i_addr,
    input  wire logic [31:0]                   i_wdata,
    input  wire logic                          i_wr,
    input  wire logic                          i_rd,
    output logic [31:0]                        o_rdata,
    // Request toward the core
    output icg_pkg::icg_cpu_req_t              o_cpu_req
);
    import icg_pkg::*;

    localparam int unsigned TOTAL = NUM_GROUPS * GROUP_LINES;

    // Line matrix; pins are synchronised before any logic reads them
    logic [TOTAL-1:0] lines_raw;
    logic [TOTAL-1:0] sync1_r;
    logic [TOTAL-1:0] sync1_nxt;
    logic [TOTAL-1:0] pend_r;
    logic [TOTAL-1:0] pend_nxt;

    icg_line_map u_map (
        .i_req   (i_req),
        .o_lines (lines_raw)
    );

    always_comb begin
        sync1_nxt = i_rst ? '0 : lines_raw;
        pend_nxt  = i_rst ? '0 : sync1_r;
    end

    always_ff @(posedge i_clock) begin
        sync1_r <= sync1_nxt;
        pend_r  <= pend_nxt;
    end

    // Group configuration
    icg_group_cfg_t [NUM_GROUPS-1:0] cfg_r;
    icg_group_cfg_t [NUM_GROUPS-1:0] cfg_nxt;
    logic [NUM_GROUPS-1:0]           grp_valid;
    logic [NUM_GROUPS*LEVEL_W-1:0]   grp_level;
    logic [GROUP_W-1:0]              widx;
    logic                            prio_hit;

    assign widx     = i_addr[GROUP_W+1:2];
    assign prio_hit = i_addr[ADDR_W-1:8] == PRIO_BASE_OFS[ADDR_W-1:8]
                      && i_addr[1:0] == 2'h0;

    always_comb begin
        cfg_nxt = cfg_r;
        if (i_rst) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                cfg_nxt[g].level  = PRIO_RESET[LEVEL_LSB +: LEVEL_W];
                cfg_nxt[g].offset = PRIO_RESET[OFFSET_LSB +: OFFSET_W];
            end
        end else if (i_wr && prio_hit) begin
            cfg_nxt[widx].level  = i_wdata[LEVEL_LSB +: LEVEL_W];
            cfg_nxt[widx].offset = i_wdata[OFFSET_LSB +: OFFSET_W];
        end
    end

    always_ff @(posedge i_clock) begin
        cfg_r <= cfg_nxt;
    end

    // One valid flag per group, any line of it pending
    always_comb begin
        for (int g = 0; g < NUM_GROUPS; g++) begin
            grp_valid[g] = |pend_r[g*GROUP_LINES +: GROUP_LINES];
            grp_level[g*LEVEL_W +: LEVEL_W] = cfg_r[g].level;
        end
    end

    // Per-level selection
    logic [NUM_LEVELS-1:0]            lvl_any;
    logic [NUM_LEVELS*GROUP_W-1:0]    lvl_grp;

    for (genvar l = 0; l < NUM_LEVELS; l++) begin : g_lvl
        icg_level_pick #(
            .LEVEL (LEVEL_W'(l))
        ) u_pick (
            .i_valid (grp_valid),
            .i_level (grp_level),
            .o_any   (lvl_any[l]),
            .o_group (lvl_grp[l*GROUP_W +: GROUP_W])
        );
    end

    // Cause registers; stale value kept when a level is idle
    logic [NUM_LEVELS*GROUP_W-1:0] cause_r;
    logic [NUM_LEVELS*GROUP_W-1:0] cause_nxt;
    logic [NUM_LEVELS-1:0]         any_r;
    logic [NUM_LEVELS-1:0]         any_nxt;

    always_comb begin
        any_nxt   = i_rst ? '0 : lvl_any;
        cause_nxt = cause_r;
        if (i_rst) begin
            cause_nxt = '0;
        end else begin
            for (int l = 0; l < NUM_LEVELS; l++) begin
                if (lvl_any[l]) begin
                    cause_nxt[l*GROUP_W +: GROUP_W] =
                        lvl_grp[l*GROUP_W +: GROUP_W];
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        cause_r <= cause_nxt;
        any_r   <= any_nxt;
    end

    // Request toward the core: highest pending level, highest group in it
    icg_cpu_req_t cpu_r;
    icg_cpu_req_t cpu_nxt;

    always_comb begin
        cpu_nxt = '0;
        if (!i_rst) begin
            for (int l = 0; l < NUM_LEVELS; l++) begin
                if (any_r[l]) begin
                    cpu_nxt.valid  = 1'b1;
                    cpu_nxt.level  = LEVEL_W'(l);
                    cpu_nxt.offset =
                        cfg_r[cause_r[l*GROUP_W +: GROUP_W]].offset;
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        cpu_r <= cpu_nxt;
    end

    assign o_cpu_req = cpu_r;

    // Read path; writes outside the priority block have no effect
    logic [31:0]        rdata_r;
    logic [31:0]        rdata_nxt;
    logic [1:0]         cidx;

    // Level 3 sits at the lowest cause address
    assign cidx = 2'h3 - i_addr[3:2];

    always_comb begin
        rdata_nxt = '0;
        if (!i_rst && i_rd && i_addr[1:0] == 2'h0) begin
            if (prio_hit) begin
                rdata_nxt[LEVEL_LSB +: LEVEL_W]   = cfg_r[widx].level;
                rdata_nxt[OFFSET_LSB +: OFFSET_W] = cfg_r[widx].offset;
            end else if (i_addr >= REQ_BASE_OFS && i_addr <= REQ_LAST_OFS) begin
                rdata_nxt = pend_r[widx*GROUP_LINES +: GROUP_LINES];
            end else if (i_addr >= CAUSE_LVL3_OFS
                         && i_addr <= CAUSE_LAST_OFS) begin
                rdata_nxt[GROUP_W-1:0] =
                    cause_r[cidx*GROUP_W +: GROUP_W];
            end
        end
    end

    always_ff @(posedge i_clock) begin
        rdata_r <= rdata_nxt;
    end

    assign o_rdata = rdata_r;

endmodule
`default_nettype wire

// ### test/icg_cpu_model.sv
// Core-side model that takes the offered level and handler offset
`timescale 1ns/1ps
`default_nettype none
module icg_cpu_model (
    // Clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_rst,
    // Request from the block
    input  wire icg_pkg::icg_cpu_req_t i_req,
    // Last request taken
    output logic [1:0]                 o_level,
    output logic [13:0]                o_offset
);
    import icg_pkg::*;
    // Mask bits are not modelled, so every valid request is taken
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_level  <= 2'h0;
            o_offset <= 14'h0000;
        end else if (i_req.valid) begin
            o_level  <= i_req.level;
            o_offset <= i_req.offset;
        end
    end
endmodule
`default_nettype wire

// ### test/icg_top_asserts.sv
// Port-level assertions for the interrupt cause block
`timescale 1ns/1ps
`default_nettype none
module icg_top_chk (
    // Clock and reset
    input wire logic                    i_clock,
    input wire logic                    i_rst,
    // Observed ports
    input wire icg_pkg::icg_periph_req_t i_req,
    input wire logic [icg_pkg::ADDR_W-1:0] i_addr,
    input wire logic [31:0]             i_wdata,
    input wire logic                    i_wr,
    input wire logic                    i_rd,
    input wire logic [31:0]             o_rdata,
    input wire icg_pkg::icg_cpu_req_t   o_cpu_req
);
    import icg_pkg::*;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    rdata_idle_a:
        assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data not zero outside read");
    cause_rsvd_a:
        assert property (i_rd && i_addr inside {[CAUSE_LVL3_OFS:CAUSE_LAST_OFS]}
            |=> o_rdata[31:6] == 26'h0) else $error("cause upper bits set");
    unmapped_rd_a:
        assert property (i_rd && i_addr > CAUSE_LAST_OFS |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    prio_rsvd_a:
        assert property (i_rd && i_addr <= PRIO_LAST_OFS
            |=> o_rdata[29:14] == 16'h0) else $error("priority gap bits set");
    grp0_line_a:
        assert property (i_rd && i_addr == REQ_BASE_OFS
            |=> o_rdata[31:1] == 31'h0) else $error("group 0 extra lines");
    grp1_line_a:
        assert property (i_rd && i_addr == 12'h104
            |=> o_rdata[31:10] == 22'h0) else $error("group 1 extra lines");
    empty_grp_a:
        assert property (i_rd && i_addr inside {[12'h15C:12'h164],
            [12'h178:REQ_LAST_OFS]} |=> o_rdata == 32'h0)
        else $error("unused group shows lines");
    cpu_idle_a:
        assert property ((i_req == '0)[*6] |=> !o_cpu_req.valid)
        else $error("core request without pending line");
    cpu_hold_a:
        assert property (($stable(i_req) && !i_wr)[*6] |=> $stable(o_cpu_req))
        else $error("core request moved with quiet inputs");
    req_lat_a:
        assert property ((i_req == '0)[*6] ##1 (i_req != '0)[*4]
            |-> !o_cpu_req.valid ##1 o_cpu_req.valid)
        else $error("core request latency wrong");
    cover property (o_cpu_req.valid && o_cpu_req.level == 2'h3);
    cover property (i_rd && i_addr == CAUSE_LVL3_OFS);
    cover property (i_wr && i_addr == 12'h204);
endmodule
bind icg_top icg_top_chk u_chk (
    .i_clock(i_clock), .i_rst(i_rst), .i_req(i_req), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_cpu_req(o_cpu_req)
);
`default_nettype wire

// ### test/icg_top_bench.sv
// Self-checking bench for the interrupt cause and group map block
`timescale 1ns/1ps
`default_nettype none
module icg_top_bench;
    import icg_pkg::*;
    logic              i_clock;
    logic              i_rst;
    icg_periph_req_t   i_req;
    logic [ADDR_W-1:0] i_addr;
    logic [31:0]       i_wdata;
    logic              i_wr;
    logic              i_rd;
    logic [31:0]       o_rdata;
    icg_cpu_req_t      o_cpu_req;
    logic [1:0]        cpu_level;
    logic [13:0]       cpu_offset;
    int                bad_count = 0;
    int                check_count = 0;

    icg_top uut (.i_clock(i_clock), .i_rst(i_rst), .i_req(i_req),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_cpu_req(o_cpu_req));
    icg_cpu_model core (.i_clock(i_clock), .i_rst(i_rst), .i_req(o_cpu_req),
        .o_level(cpu_level), .o_offset(cpu_offset));

    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Core model output moves on the clock edge, so look just after it
    task automatic chk_core(input logic [31:0] exp);
        #1 chk({cpu_level, 16'h0, cpu_offset}, exp);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask

    // Six edges cover the four-stage path to the core request
    task automatic req(input icg_periph_req_t r);
        @(posedge i_clock);
        i_req <= r;
        repeat (6) @(posedge i_clock);
    endtask

    task automatic mp(input icg_periph_req_t r, input int g, input int l);
        req(r);
        rd(REQ_BASE_OFS + 12'(4 * g), 32'h1 << l);
        rd(CAUSE_LAST_OFS, 32'(g));
        req('0);
    endtask

    task automatic t_reg();
        rd(12'h024, PRIO_RESET);
        wr(PRIO_LAST_OFS, 32'h4000_3FFF);
        rd(PRIO_LAST_OFS, 32'h4000_3FFF);
    endtask

    task automatic t_map();
        mp('{core_system_request: 1'b1, default: '0}, 0, 0);
        mp('{ext_line: 8'h80, default: '0}, 1, 7);
        mp('{rtc: 1'b1, default: '0}, 1, 8);
        mp('{power: 1'b1, default: '0}, 1, 9);
        mp('{port_line: 14'h2000, default: '0}, 2, 13);
        mp('{pdma: 8'h80, default: '0}, 3, 7);
        mp('{flash: 1'b1, default: '0}, 4, 0);
        mp('{usart: 4'h8, default: '0}, 8, 0);
        mp('{twi_master: 2'h2, default: '0}, 12, 0);
        mp('{timer0: 3'h4, default: '0}, 14, 2);
        mp('{timer1: 3'h1, default: '0}, 16, 0);
        mp('{dmac: 5'h10, default: '0}, 22, 4);
        mp('{twi_slave: 2'h1, default: '0}, 27, 0);
        mp('{ecc_corrector_request: 1'b1, default: '0}, 29, 0);
        mp('{spi: 2'h2, default: '0}, 10, 0);
        mp('{ssc: 1'b1, default: '0}, 13, 0);
        mp('{adc: 1'b1, default: '0}, 15, 0);
        mp('{usb: 1'b1, default: '0}, 17, 0);
        mp('{sdram: 1'b1, default: '0}, 18, 0);
        mp('{dac: 1'b1, default: '0}, 19, 0);
        mp('{mci: 1'b1, default: '0}, 20, 0);
        mp('{aes: 1'b1, default: '0}, 21, 0);
        mp('{msi: 1'b1, default: '0}, 26, 0);
    endtask

    task automatic t_cause();
        wr(12'h00C, 32'h0000_0010);
        wr(12'h014, 32'h8000_0050);
        wr(12'h024, 32'h8000_0090);
        wr(12'h074, 32'hC000_01D0);
        req('{usart: 4'h1, spi: 2'h1, pdma: 8'h01,
            ecc_corrector_request: 1'b1, default: '0});
        rd(CAUSE_LVL3_OFS, 32'h0000_001D);
        rd(12'h204, 32'h0000_0009);
        rd(CAUSE_LAST_OFS, 32'h0000_0003);
        chk_core(32'hC000_01D0);
        wr(12'h204, 32'h0000_003F);
        rd(12'h204, 32'h0000_0009);
        rd(12'h300, 32'h0000_0000);
        rd(12'h205, 32'h0000_0000);
        wr(12'h040, 32'h4000_0160);
        req('{usart: 4'h1, spi: 2'h1, pdma: 8'h01, timer1: 3'h6,
            default: '0});
        chk_core(32'h8000_0090);
        rd(12'h208, 32'h0000_0010);
        rd(12'h140, 32'h0000_0006);
        // Level 1 goes idle once group 16 moves up, so it is not read then
        req('{usart: 4'h1, pdma: 8'h01, timer1: 3'h6, default: '0});
        rd(12'h204, 32'h0000_0005);
        chk_core(32'h8000_0050);
        wr(12'h040, 32'hC000_0160);
        repeat (4) @(posedge i_clock);
        rd(CAUSE_LVL3_OFS, 32'h0000_0010);
        chk_core(32'hC000_0160);
        req('0);
    endtask

    initial begin
        i_rst   = 1'b1;
        i_req   = '0;
        i_addr  = '0;
        i_wdata = 32'h0;
        i_wr    = 1'b0;
        i_rd    = 1'b0;
        repeat (6) @(posedge i_clock);
        i_rst <= 1'b0;
        t_reg();
        t_map();
        t_cause();
        summarize();
    end

    initial begin
        repeat (3000) @(posedge i_clock);
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
